// *** pkg/cbc_pkg.sv ***
// Purpose: Shared constants and types for the cell balance controller
// Assumes: 50 MHz system clock, synchronous active-high reset
// Notes:   Register selects, field layout, reset values and timing figures
`default_nettype none
package cbc_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_HZ      = 50_000_000;          // System clock rate
   localparam int TICK_TIME_S = 1;                   // Base time step, seconds
   localparam int TICK_CYCLES = CLK_HZ * TICK_TIME_S; // Cycles per step
   localparam int DUR_STEP_S  = 20;                  // Timed duration step, seconds
   localparam int AUTO_ON_S   = 1;                   // Auto on-time per cycle, seconds
   localparam int WDOG_TIME_S = 30;                  // Watchdog timeout, seconds

   // ****************************************
   // Sizes and register selects
   // ****************************************
   localparam int         NUM_CELLS  = 12;
   localparam int         NUM_INST   = 13;
   localparam logic [1:0] ADDR_CTRL  = 2'h0;  // balance_control
   localparam logic [1:0] ADDR_CELLS = 2'h1;  // balance_cell_select at pointer
   localparam logic [1:0] ADDR_TIME  = 2'h2;  // balance_duration
   localparam logic [1:0] ADDR_STAT  = 2'h3;  // Flags, write one to clear
   localparam int         STAT_DONE  = 0;     // balance_done_flag position
   localparam int         STAT_WDOG  = 1;     // watchdog_expired_flag position

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [9:0]  CTRL_RESET  = 10'h000;
   localparam logic [11:0] CELLS_RESET = 12'h000;
   localparam logic [6:0]  DUR_RESET   = 7'h00;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      MODE_OFF    = 2'h0,
      MODE_MANUAL = 2'h1,
      MODE_TIMED  = 2'h2,
      MODE_AUTO   = 2'h3
   } cbc_mode_t;

   // balance_control: run bit 9, pointer 8:5, wait 4:2, mode 1:0
   typedef struct packed {
      logic       balance_run;
      logic [3:0] select_pointer;
      logic [2:0] cycle_wait;
      cbc_mode_t  mode;
   } cbc_ctrl_t;

   typedef enum logic [2:0] {
      A_IDLE = 3'b001,
      A_ON   = 3'b010,
      A_WAIT = 3'b100
   } cbc_auto_t;

   // Decoded link commands, one-cycle pulses
   typedef struct packed {
      logic enable;   // Balance Enable, broadcast
      logic inhibit;  // Balance Inhibit, broadcast
      logic sleep;    // Sleep command
      logic wakeup;   // Valid Wakeup command
      logic comm_ok;  // Valid communication seen
   } cbc_cmd_t;
endpackage
`default_nettype wire

// *** hw/cbc_balance_ctrl.sv ***
// Purpose: Twelve-gate cell balance controller, off/manual/timed/auto
// Assumes: Commands already decoded; auto charge accounting is external
// Notes:
// Functional notes
// - twelve independent balance gate outputs
// - two-bit mode: off, manual, timed, auto
// - manual drives gates straight from selection
// - timed switches gates off after duration
// - auto removes programmed charge over cycles
// - auto wait code gives 0,1..64 seconds
// - run bit starts balancing, register or command
// - select bit n drives cell n+1
// - thirteen select instances, pointer picks one
// - manual and timed use instance zero
// - auto steps pointer through instances 1-12
// - all-zero instance wraps back to one
// - clear run or inhibit stops balancing
// - broadcast enable and inhibit accepted
// - watchdog expiry in manual stops, sleeps
// - wakeup resumes manual with prior selection unless watchdog expired
// - sleep without watchdog stops and sleeps
// - sleep with watchdog still flags expiry
// - seven-bit duration, 20 s steps, zero disables
// - timed or auto end sets done, clears run
`timescale 1ns/1ps
`default_nettype none
module cbc_balance_ctrl #(
   parameter int SEC_CYCLES = cbc_pkg::TICK_CYCLES  // Shorten in simulation
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset,
   // Register port
   input  wire logic [1:0]        reg_addr,
   input  wire logic              reg_wr,
   input  wire logic [15:0]       reg_wdata,
   output logic      [15:0]       reg_rdata,
   // Decoded commands and status inputs
   input  wire cbc_pkg::cbc_cmd_t cmd,
   input  wire logic              watchdog_enable,
   input  wire logic              auto_charge_met,
   // Gate and status outputs
   output logic      [11:0]       gate_out_cell,
   output logic                   sleep_mode,
   output logic                   balance_done_flag,
   output logic                   watchdog_expired_flag
);
   // ****************************************
   // State
   // ****************************************
   logic [25:0]        tick_cnt;      // One-second prescaler
   logic [25:0]        next_tick_cnt;
   logic               tick;          // One-second strobe
   cbc_pkg::cbc_ctrl_t ctrl;          // balance_control
   cbc_pkg::cbc_ctrl_t next_ctrl;
   logic [11:0]        cells [cbc_pkg::NUM_INST];      // Select instances
   logic [11:0]        next_cells [cbc_pkg::NUM_INST];
   logic [6:0]         dur;           // balance_duration
   logic [6:0]         next_dur;
   logic [11:0]        sec_cnt;       // Timed elapsed seconds
   logic [11:0]        next_sec_cnt;
   logic [6:0]         phase;         // Auto seconds in phase
   logic [6:0]         next_phase;
   cbc_pkg::cbc_auto_t auto_st;       // Auto sequencer
   cbc_pkg::cbc_auto_t next_auto_st;
   logic [7:0]         wd_cnt;        // Watchdog seconds left
   logic [7:0]         next_wd_cnt;
   logic               next_sleep;
   logic               next_done;
   logic               next_wdog;
   logic [11:0]        next_gate;
   logic [15:0]        next_rdata;
   logic               timed_fire;    // Timed duration reached
   logic               auto_fire;     // Auto charge target met
   logic               wd_fire;       // Watchdog ran out
   logic [3:0]         adv_ptr;       // Next auto pointer
   logic [11:0]        sel_now;       // Instance at pointer

   // Wait code to seconds, doubling per code
   function automatic logic [6:0] wait_secs(input logic [2:0] code);
      wait_secs = (code == 3'h0) ? 7'h00 : (7'h01 << (code - 3'h1));
   endfunction

   // ****************************************
   // Prescaler
   // ****************************************
   // Free-running second strobe shared by every timer
   always_comb begin
      tick          = (tick_cnt == 26'(SEC_CYCLES - 1));
      next_tick_cnt = tick ? 26'h0000000 : tick_cnt + 26'h0000001;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         tick_cnt <= 26'h0000000;
      end else begin
         tick_cnt <= next_tick_cnt;
      end
   end

   // ****************************************
   // Control next state
   // ****************************************
   always_comb begin
      next_ctrl    = ctrl;
      next_cells   = cells;
      next_dur     = dur;
      next_sec_cnt = sec_cnt;
      next_phase   = phase;
      next_auto_st = auto_st;
      next_wd_cnt  = wd_cnt;
      next_sleep   = sleep_mode;
      timed_fire   = 1'b0;
      auto_fire    = 1'b0;
      wd_fire      = 1'b0;
      // Out-of-range pointer reads as empty
      sel_now = (ctrl.select_pointer < 4'(cbc_pkg::NUM_INST)) ?
                cells[ctrl.select_pointer] : 12'h000;
      // Wrap when at last instance or next one is empty
      if (ctrl.select_pointer >= 4'(cbc_pkg::NUM_CELLS) ||
          cells[ctrl.select_pointer + 4'h1] == 12'h000) begin
         adv_ptr = 4'h1;
      end else begin
         adv_ptr = ctrl.select_pointer + 4'h1;
      end

      // Register writes
      if (reg_wr) begin
         case (reg_addr)
            cbc_pkg::ADDR_CTRL: begin
               next_ctrl = cbc_pkg::cbc_ctrl_t'(reg_wdata[9:0]);
            end
            cbc_pkg::ADDR_CELLS: begin
               // Writes past the last instance are dropped
               if (ctrl.select_pointer < 4'(cbc_pkg::NUM_INST)) begin
                  next_cells[ctrl.select_pointer] = reg_wdata[11:0];
               end
            end
            cbc_pkg::ADDR_TIME: begin
               next_dur = reg_wdata[6:0];
            end
            default: begin
            end
         endcase
      end

      // Broadcast commands; inhibit beats enable
      if (cmd.enable) begin
         next_ctrl.balance_run = 1'b1;
      end
      if (cmd.inhibit) begin
         next_ctrl.balance_run = 1'b0;
      end

      // Sleep and wakeup; run bit is kept so wakeup resumes
      if (cmd.sleep) begin
         next_sleep = 1'b1;
      end else if (cmd.wakeup) begin
         next_sleep = 1'b0;
      end

      // Watchdog keeps running in sleep so expiry is still flagged
      if (!watchdog_enable || cmd.comm_ok) begin
         next_wd_cnt = 8'(cbc_pkg::WDOG_TIME_S);
      end else if (tick && wd_cnt != 8'h00) begin
         next_wd_cnt = wd_cnt - 8'h01;
         wd_fire     = (wd_cnt == 8'h01);
      end
      if (wd_fire) begin
         next_sleep = 1'b1;
         if (ctrl.mode == cbc_pkg::MODE_MANUAL) begin
            next_ctrl.balance_run = 1'b0;
         end
      end

      // Timed: timer runs on through sleep, zero code never ends
      if (ctrl.balance_run && ctrl.mode == cbc_pkg::MODE_TIMED && tick) begin
         next_sec_cnt = sec_cnt + 12'h001;
         if (dur != 7'h00 &&
             next_sec_cnt >= 12'({5'h00, dur} * 12'(cbc_pkg::DUR_STEP_S))) begin
            timed_fire = 1'b1;
         end
      end

      // Auto: charge target reported by external accounting
      if (ctrl.balance_run && ctrl.mode == cbc_pkg::MODE_AUTO && auto_charge_met) begin
         auto_fire = 1'b1;
      end

      // Auto sequencer, frozen while asleep
      if (ctrl.balance_run && ctrl.mode == cbc_pkg::MODE_AUTO && !sleep_mode && tick) begin
         next_phase = phase + 7'h01;
         case (auto_st)
            cbc_pkg::A_ON: begin
               if (next_phase >= 7'(cbc_pkg::AUTO_ON_S)) begin
                  next_phase = 7'h00;
                  if (wait_secs(ctrl.cycle_wait) == 7'h00) begin
                     next_ctrl.select_pointer = adv_ptr;
                  end else begin
                     next_auto_st = cbc_pkg::A_WAIT;
                  end
               end
            end
            cbc_pkg::A_WAIT: begin
               if (next_phase >= wait_secs(ctrl.cycle_wait)) begin
                  next_phase               = 7'h00;
                  next_auto_st             = cbc_pkg::A_ON;
                  next_ctrl.select_pointer = adv_ptr;
               end
            end
            default: begin
               next_phase = 7'h00;
            end
         endcase
      end

      // End of timed or auto run
      if (timed_fire || auto_fire) begin
         next_ctrl.balance_run = 1'b0;
      end

      // Fresh start restarts timers and the auto sequence
      if (next_ctrl.balance_run && !ctrl.balance_run) begin
         next_sec_cnt = 12'h000;
         next_phase   = 7'h00;
         if (next_ctrl.mode == cbc_pkg::MODE_AUTO) begin
            next_auto_st             = cbc_pkg::A_ON;
            next_ctrl.select_pointer = 4'h1;
         end
      end
      if (!next_ctrl.balance_run || next_ctrl.mode != cbc_pkg::MODE_AUTO) begin
         next_auto_st = cbc_pkg::A_IDLE;
      end
   end

   // ****************************************
   // Flags, gates and read data
   // ****************************************
   // Hardware set wins over a same-cycle clear
   always_comb begin
      next_done = timed_fire || auto_fire || (balance_done_flag &&
                  !(reg_wr && reg_addr == cbc_pkg::ADDR_STAT &&
                    reg_wdata[cbc_pkg::STAT_DONE]));
      next_wdog = wd_fire || (watchdog_expired_flag &&
                  !(reg_wr && reg_addr == cbc_pkg::ADDR_STAT &&
                    reg_wdata[cbc_pkg::STAT_WDOG]));
      // Gates follow next state so they move with the control bits
      next_gate = 12'h000;
      if (next_ctrl.balance_run && !next_sleep) begin
         case (next_ctrl.mode)
            cbc_pkg::MODE_MANUAL, cbc_pkg::MODE_TIMED: begin
               next_gate = next_cells[0];
            end
            cbc_pkg::MODE_AUTO: begin
               if (next_auto_st == cbc_pkg::A_ON &&
                   next_ctrl.select_pointer < 4'(cbc_pkg::NUM_INST)) begin
                  next_gate = next_cells[next_ctrl.select_pointer];
               end
            end
            default: begin
               next_gate = 12'h000;
            end
         endcase
      end
      case (reg_addr)
         cbc_pkg::ADDR_CTRL:  next_rdata = {6'h00, ctrl};
         cbc_pkg::ADDR_CELLS: next_rdata = {4'h0, sel_now};
         cbc_pkg::ADDR_TIME:  next_rdata = {9'h000, dur};
         default:             next_rdata = {14'h0000, watchdog_expired_flag,
                                            balance_done_flag};
      endcase
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl                  <= cbc_pkg::cbc_ctrl_t'(cbc_pkg::CTRL_RESET);
         for (int i = 0; i < cbc_pkg::NUM_INST; i++) begin
            cells[i] <= cbc_pkg::CELLS_RESET;
         end
         dur                   <= cbc_pkg::DUR_RESET;
         sec_cnt               <= 12'h000;
         phase                 <= 7'h00;
         auto_st               <= cbc_pkg::A_IDLE;
         wd_cnt                <= 8'(cbc_pkg::WDOG_TIME_S);
         sleep_mode            <= 1'b0;
         balance_done_flag     <= 1'b0;
         watchdog_expired_flag <= 1'b0;
         gate_out_cell         <= 12'h000;
         reg_rdata             <= 16'h0000;
      end else begin
         ctrl                  <= next_ctrl;
         cells                 <= next_cells;
         dur                   <= next_dur;
         sec_cnt               <= next_sec_cnt;
         phase                 <= next_phase;
         auto_st               <= next_auto_st;
         wd_cnt                <= next_wd_cnt;
         sleep_mode            <= next_sleep;
         balance_done_flag     <= next_done;
         watchdog_expired_flag <= next_wdog;
         gate_out_cell         <= next_gate;
         reg_rdata             <= next_rdata;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_timed_end;
      timed_fire ##1 !ctrl.balance_run;
   endsequence
   sequence s_wake_manual;
      cmd.wakeup && !cmd.sleep && !cmd.inhibit && !wd_fire && !reg_wr &&
      ctrl.balance_run && ctrl.mode == cbc_pkg::MODE_MANUAL;
   endsequence

   property p_idle_off;
      (!ctrl.balance_run || ctrl.mode == cbc_pkg::MODE_OFF) |-> gate_out_cell == 12'h000;
   endproperty
   a_idle_off: assert property (p_idle_off) else $error("gates on while idle");
   property p_manual_direct;
      (ctrl.balance_run && ctrl.mode == cbc_pkg::MODE_MANUAL && !sleep_mode)
         |-> gate_out_cell == cells[0];
   endproperty
   a_manual_direct: assert property (p_manual_direct) else $error("manual gate mismatch");
   property p_inhibit;
      cmd.inhibit |=> !ctrl.balance_run && gate_out_cell == 12'h000;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("inhibit did not stop");
   property p_enable;
      (cmd.enable && !cmd.inhibit && !wd_fire && !timed_fire && !auto_fire &&
       !(reg_wr && reg_addr == cbc_pkg::ADDR_CTRL)) |=> ctrl.balance_run;
   endproperty
   a_enable: assert property (p_enable) else $error("enable did not set run");
   property p_sleep;
      cmd.sleep |=> sleep_mode && gate_out_cell == 12'h000;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep did not stop gates");
   property p_timed_done;
      s_timed_end |-> balance_done_flag && gate_out_cell == 12'h000;
   endproperty
   a_timed_done: assert property (p_timed_done) else $error("timed end wrong");
   property p_wdog;
      wd_fire |=> watchdog_expired_flag && sleep_mode;
   endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog expiry not flagged");
   property p_auto_ptr;
      (auto_st != cbc_pkg::A_IDLE) |-> ctrl.select_pointer >= 4'h1 &&
         ctrl.select_pointer <= 4'(cbc_pkg::NUM_CELLS);
   endproperty
   a_auto_ptr: assert property (p_auto_ptr) else $error("auto pointer out of range");
   property p_wake;
      s_wake_manual |=> !sleep_mode && gate_out_cell == cells[0];
   endproperty
   a_wake: assert property (p_wake) else $error("wakeup did not resume");
endmodule
`default_nettype wire

// *** verification/cbc_host_model.sv ***
// Purpose: Host controller model for the balance register port and commands
// Assumes: Requests launch just after a rising edge and hold to the sampling edge
// Notes:   The testbench calls these tasks; the model keeps the host's setup order
`timescale 1ns/1ps
`default_nettype none
module cbc_host_model (
   // Clock
   input  wire logic              clk,
   // Register port
   output logic      [1:0]        reg_addr,
   output logic                   reg_wr,
   output logic      [15:0]       reg_wdata,
   input  wire logic [15:0]       reg_rdata,
   // Command pulses
   output cbc_pkg::cbc_cmd_t      cmd
);
   // ****************************************
   // Bus tasks
   // ****************************************
   // Idle bus from time zero
   initial begin
      reg_addr  = 2'h0;
      reg_wr    = 1'b0;
      reg_wdata = 16'h0000;
      cmd       = '0;
   end

   // One write; data inverted after use so stale values never look valid
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wr    <= 1'b1;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_wdata <= ~d;
   endtask

   // Read: data is registered one cycle after the select settles
   task automatic rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      @(posedge clk);
      #1;
      d = reg_rdata;
   endtask

   // One-cycle command pulse
   task automatic send(input cbc_pkg::cbc_cmd_t c);
      @(posedge clk);
      cmd <= c;
      @(posedge clk);
      cmd <= '0;
   endtask

   // Manual setup: mode and pointer zero first, cells next, run last
   task automatic start_manual(input logic [11:0] sel);
      wr(cbc_pkg::ADDR_CTRL, 16'h0001);
      wr(cbc_pkg::ADDR_CELLS, {4'h0, sel});
      wr(cbc_pkg::ADDR_CTRL, 16'h0201);
   endtask
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// Purpose: Self-checking bench for the cell balance controller
// Assumes: Short second of 10 clocks; fixed random seed
// Notes:   Expected times allow for the free-running second tick
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // ****************************************
   // Signals and helpers
   // ****************************************
   localparam int SEC = 10;                    // Clocks per second in simulation
   localparam logic [1:0] A_C = cbc_pkg::ADDR_CTRL;
   localparam logic [1:0] A_S = cbc_pkg::ADDR_CELLS;
   localparam cbc_pkg::cbc_cmd_t C_EN = 5'h10; // Enable, inhibit, sleep, wake, ok
   localparam cbc_pkg::cbc_cmd_t C_IN = 5'h08;
   localparam cbc_pkg::cbc_cmd_t C_SL = 5'h04;
   localparam cbc_pkg::cbc_cmd_t C_WK = 5'h02;
   logic clk, reset, wd_en, charge_met, reg_wr, slp, done, wdx;
   logic [1:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, rv;
   logic [11:0] gates, sel, pa, pb;
   logic [11:0] inst [13];
   cbc_pkg::cbc_cmd_t cmd;
   int err_count, num_checks, n, gap, ws;

   always #10 clk = ~clk;                      // 50 MHz

   cbc_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cmd(cmd));

   cbc_balance_ctrl #(.SEC_CYCLES(SEC)) DUT (.clk(clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .cmd(cmd), .watchdog_enable(wd_en),
      .auto_charge_met(charge_met), .gate_out_cell(gates), .sleep_mode(slp),
      .balance_done_flag(done), .watchdog_expired_flag(wdx));

   // Control word: run 9, pointer 8:5, wait 4:2, mode 1:0
   function automatic logic [15:0] cw(input logic r, input logic [3:0] p,
                                      input logic [2:0] w, input cbc_pkg::cbc_mode_t m);
      return {6'h00, r, p, w, m};
   endfunction

   function automatic int wait_secs(input int code);
      return (code == 0) ? 0 : (1 << (code - 1));
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic in_range(input int v, input int lo, input int hi);
      check({15'h0000, (v >= lo) && (v <= hi)}, 16'h0001);
   endtask

   task automatic w(input logic [1:0] a, input logic [15:0] d);
      host.wr(a, d);
      #1;
   endtask

   task automatic s(input cbc_pkg::cbc_cmd_t c);
      host.send(c);
      #1;
   endtask

   // Bounded waits, counting clocks
   task automatic until_hi(ref logic f, input int lim, output int k);
      k = 0;
      while (f !== 1'b1 && k < lim) begin
         @(posedge clk);
         #1;
         k++;
      end
   endtask

   task automatic until_not(input logic [11:0] v, input int lim, output int k);
      k = 0;
      while (gates === v && k < lim) begin
         @(posedge clk);
         #1;
         k++;
      end
   endtask

   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Hang guard, well beyond the expected run
   initial begin
      #(20 * 30000);
      err_count++;
      stop_test();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      clk = 1'b0; reset = 1'b1; wd_en = 1'b0; charge_met = 1'b0;
      rv = $urandom(32'h13ac);
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      host.rd(A_C, rv); check(rv, 16'h0000);
      check({4'h0, gates}, 16'h0000);
      // Thirteen instances, pointer 13 refused
      for (int i = 0; i < 13; i++) begin
         inst[i] = 12'($urandom) | 12'h001;
         w(A_C, cw(1'b0, i[3:0], 3'h0, cbc_pkg::MODE_OFF));
         w(A_S, {4'h0, inst[i]});
      end
      for (int i = 0; i < 14; i++) begin
         w(A_C, cw(1'b0, i[3:0], 3'h0, cbc_pkg::MODE_OFF));
         if (i == 13) w(A_S, 16'h0fff);
         host.rd(A_S, rv);
         check(rv, (i == 13) ? 16'h0000 : {4'h0, inst[i]});
      end
      w(A_C, cw(1'b1, 4'h0, 3'h0, cbc_pkg::MODE_OFF));
      check({4'h0, gates}, 16'h0000);
      // Manual with random and edge selections
      for (int i = 0; i < 6; i++) begin
         sel = (i == 0) ? 12'hfff : (i == 1) ? 12'h001 : 12'($urandom);
         host.start_manual(sel); #1;
         check({4'h0, gates}, {4'h0, sel});
         host.rd(A_C, rv); check(rv, 16'h0201);
         w(A_C, 16'h0001); check({4'h0, gates}, 16'h0000);
         s(C_EN); check({4'h0, gates}, {4'h0, sel});
         s(C_IN); check({4'h0, gates}, 16'h0000);
      end
      s(C_EN | C_IN); check({4'h0, gates}, 16'h0000);
      // Sleep without watchdog, then resume
      s(C_EN); s(C_SL);
      check({3'h0, slp, gates}, 16'h1000);
      s(C_WK); check({3'h0, slp, gates}, {4'h0, sel});
      // Timed: code zero never ends, then 20 s from a fresh start
      w(cbc_pkg::ADDR_TIME, 16'h0000);
      w(A_C, cw(1'b1, 4'h0, 3'h0, cbc_pkg::MODE_TIMED));
      until_hi(done, 25 * SEC, n); check({3'h0, done, gates}, {4'h0, sel});
      w(A_C, 16'h0002); w(cbc_pkg::ADDR_TIME, 16'h0001);
      host.rd(cbc_pkg::ADDR_TIME, rv); check(rv, 16'h0001);
      w(A_C, cw(1'b1, 4'h0, 3'h0, cbc_pkg::MODE_TIMED));
      check({4'h0, gates}, {4'h0, sel});
      until_hi(done, 400, n); in_range(n, 19 * SEC - 1, 20 * SEC + 3);
      @(posedge clk); #1; check({4'h0, gates}, 16'h0000);
      host.rd(A_C, rv); check(rv & 16'h0200, 16'h0000);
      w(cbc_pkg::ADDR_STAT, 16'h0001); check({15'h0, done}, 16'h0000);
      // Auto: two patterns then a zero instance, every wait code
      pa = (12'($urandom) & 12'h7ff) | 12'h001;
      pb = ~pa;
      w(A_C, cw(1'b0, 4'h1, 3'h0, cbc_pkg::MODE_AUTO)); w(A_S, {4'h0, pa});
      w(A_C, cw(1'b0, 4'h2, 3'h0, cbc_pkg::MODE_AUTO)); w(A_S, {4'h0, pb});
      w(A_C, cw(1'b0, 4'h3, 3'h0, cbc_pkg::MODE_AUTO)); w(A_S, 16'h0000);
      for (int c = 0; c < 8; c++) begin
         ws = wait_secs(c) * SEC;
         w(A_C, cw(1'b1, 4'h1, c[2:0], cbc_pkg::MODE_AUTO));
         check({4'h0, gates}, {4'h0, pa});
         until_not(pa, 3 * SEC, n);
         until_not(12'h000, 700, gap); in_range(gap, ws - 2, ws + 2);
         check({4'h0, gates}, {4'h0, pb});
         until_not(pb, 3 * SEC, n); until_not(12'h000, 700, n);
         check({4'h0, gates}, {4'h0, pa});
         w(A_C, cw(1'b0, 4'h1, c[2:0], cbc_pkg::MODE_AUTO));
         check({4'h0, gates}, 16'h0000);
      end
      w(A_C, cw(1'b1, 4'h1, 3'h1, cbc_pkg::MODE_AUTO));
      @(posedge clk) charge_met <= 1'b1;
      @(posedge clk) charge_met <= 1'b0;
      #1; check({3'h0, done, gates}, 16'h1000);
      w(cbc_pkg::ADDR_STAT, 16'h0001);
      // Watchdog expiry in manual
      host.start_manual(sel);
      @(posedge clk) wd_en <= 1'b1;
      #1; until_hi(wdx, 400, n); in_range(n, 29 * SEC - 2, 30 * SEC + 3);
      @(posedge clk); #1; check({3'h0, slp, gates}, 16'h1000);
      host.rd(A_C, rv); check(rv & 16'h0200, 16'h0000);
      host.rd(cbc_pkg::ADDR_STAT, rv); check(rv, 16'h0002);
      @(posedge clk) wd_en <= 1'b0;
      w(cbc_pkg::ADDR_STAT, 16'h0002); s(C_WK);
      check({2'h0, slp, wdx, gates}, 16'h0000);
      // Sleep with watchdog on still flags expiry later
      s(C_EN); check({4'h0, gates}, {4'h0, sel});
      @(posedge clk) wd_en <= 1'b1;
      s(5'h01); s(C_SL);
      check({2'h0, slp, wdx, gates}, 16'h2000);
      until_hi(wdx, 400, n); in_range(n, 27 * SEC, 30 * SEC + 3);
      stop_test();
   end
endmodule
`default_nettype wire
